/* trd_defs.vh */
// shared constants for the trinary remote decoder
`ifndef TRD_DEFS_VH
`define TRD_DEFS_VH

`define TRD_CLK_NS 8
`define TRD_TICK_NS 1000
`define TRD_CELL_TICKS 8'h10
`define TRD_SAMPLE_TICK 8'h08
`define TRD_WORD_GAP_TICKS 8'h20
`define TRD_SEQ_GAP_TICKS 8'h80
`define TRD_IDLE_MAX 8'hFF

`define TRD_DIGITS 9
`define TRD_WORD_W 18
`define TRD_LAST_BIT 5'h11
`define TRD_FIFO_W 19
`define TRD_FIFO_DEPTH 16
`define TRD_FIFO_AW 4
`define TRD_MARK_BIT 18
`define TRD_ADDR5_HI 17
`define TRD_ADDR5_LO 8

`define TRD_DIG_LOW 2'h0
`define TRD_DIG_OPEN 2'h2
`define TRD_DIG_HIGH 2'h3

`define TRD_RX_IDLE 2'h0
`define TRD_RX_BIT 2'h1
`define TRD_RX_WAIT 2'h2

`define TRD_CMP_IDLE 1'b0
`define TRD_CMP_CHECK 1'b1

`endif

/* trd_fifo.v */
// word fifo with registered read data between receiver and comparator
`timescale 1ns/1ps
module trd_fifo #(
    parameter W = 19,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    input wire clk,
    input wire nrst,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output wire in_ready,
    output reg out_valid,
    output reg [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr;
    wire do_rd;
    wire mem_empty;

    assign mem_empty = (count_reg == {(AW+1){1'b0}});
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign do_wr = in_valid && in_ready;
    // refill the output stage when it is empty or being taken this cycle
    assign do_rd = !mem_empty && (!out_valid || out_ready);

    always @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_data <= mem[rd_ptr_reg];
                out_valid <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid <= 1'b0;
            end
            if (do_wr && !do_rd)
            begin
                count_reg <= count_reg + 1'b1;
            end
            else if (!do_wr && do_rd)
            begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

/* trd_decoder.v */
// trinary remote decoder: serial receiver, word fifo and pair confirmation
`timescale 1ns/1ps
`include "trd_defs.vh"
module trd_decoder
(
    input wire CLK,
    input wire NRST,
    input wire SERIAL_IN,
    input wire ADDR_ONLY_MODE,
    input wire [17:0] LOCAL_ADDR_DIGITS,
    output reg DATA_OUT_BIT0,
    output reg DATA_OUT_BIT1,
    output reg DATA_OUT_BIT2,
    output reg DATA_OUT_BIT3,
    output reg VALID_FRAME_FLAG,
    output reg WORD_OVERRUN
);
    localparam SYNC_W = 20;
    localparam TICK_FULL = ((`TRD_TICK_NS + `TRD_CLK_NS - 1) / `TRD_CLK_NS);
    localparam [6:0] TICK_CYC = TICK_FULL[6:0];

    // pin synchroniser: three stages, a change counts once stages 2 and 3 agree
    reg [SYNC_W-1:0] s1_reg;
    reg [SYNC_W-1:0] s2_reg;
    reg [SYNC_W-1:0] s3_reg;
    reg [SYNC_W-1:0] filt_reg;
    wire [SYNC_W-1:0] filt_next;
    wire din;
    wire mode_addr_only;
    wire [`TRD_WORD_W-1:0] local_addr;

    assign filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    assign din = filt_reg[0];
    assign local_addr = filt_reg[`TRD_WORD_W:1];
    assign mode_addr_only = filt_reg[SYNC_W-1];

    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            s1_reg <= {SYNC_W{1'b0}};
            s2_reg <= {SYNC_W{1'b0}};
            s3_reg <= {SYNC_W{1'b0}};
            filt_reg <= {SYNC_W{1'b0}};
        end
        else
        begin
            s1_reg <= {ADDR_ONLY_MODE, LOCAL_ADDR_DIGITS, SERIAL_IN};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
        end
    end

    // timing tick divider replaces the external rc oscillator
    reg [6:0] div_reg;
    reg tick_reg;

    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            div_reg <= 7'h00;
            tick_reg <= 1'b0;
        end
        else if (div_reg == TICK_CYC - 7'h01)
        begin
            div_reg <= 7'h00;
            tick_reg <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 7'h01;
            tick_reg <= 1'b0;
        end
    end

    // serial receiver: every bit cell opens with a rising edge; level at the
    // sample point gives the bit, two bits give one digit
    reg [1:0] rx_state_reg;
    reg din_prev_reg;
    reg [7:0] idle_reg;
    reg [4:0] bit_cnt_reg;
    reg [`TRD_WORD_W-1:0] shift_reg;
    reg brk_pend_reg;
    reg word_done;
    reg word_abort;
    reg seq_end;
    wire rise;
    wire fifo_in_ready;
    wire fifo_in_valid;
    wire [`TRD_FIFO_W-1:0] fifo_in_data;
    wire [`TRD_WORD_W-1:0] word_full;

    assign rise = din && !din_prev_reg;
    assign word_full = {shift_reg[`TRD_WORD_W-2:0], din};

    always @*
    begin
        word_done = 1'b0;
        word_abort = 1'b0;
        seq_end = 1'b0;
        if (tick_reg)
        begin
            case (rx_state_reg)
                `TRD_RX_BIT:
                begin
                    word_done = !rise && (idle_reg == `TRD_SAMPLE_TICK)
                        && (bit_cnt_reg == `TRD_LAST_BIT);
                end
                `TRD_RX_WAIT:
                begin
                    word_abort = !rise && (idle_reg == `TRD_WORD_GAP_TICKS);
                end
                `TRD_RX_IDLE:
                begin
                    seq_end = !rise && (idle_reg == `TRD_SEQ_GAP_TICKS);
                end
                default:
                begin
                    word_abort = 1'b0;
                end
            endcase
        end
    end

    // a pending break marker goes ahead of any word so the pairing order holds
    assign fifo_in_valid = brk_pend_reg || word_done;
    assign fifo_in_data = brk_pend_reg ? {1'b1, {`TRD_WORD_W{1'b0}}} : {1'b0, word_full};

    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            rx_state_reg <= `TRD_RX_IDLE;
            din_prev_reg <= 1'b0;
            idle_reg <= 8'h00;
            bit_cnt_reg <= 5'h00;
            shift_reg <= {`TRD_WORD_W{1'b0}};
            brk_pend_reg <= 1'b0;
            WORD_OVERRUN <= 1'b0;
        end
        else
        begin
            din_prev_reg <= din;
            if (rise)
            begin
                idle_reg <= 8'h00;
            end
            else if (tick_reg && idle_reg != `TRD_IDLE_MAX)
            begin
                idle_reg <= idle_reg + 8'h01;
            end
            case (rx_state_reg)
                `TRD_RX_IDLE:
                begin
                    if (rise)
                    begin
                        rx_state_reg <= `TRD_RX_BIT;
                        bit_cnt_reg <= 5'h00;
                    end
                end
                `TRD_RX_BIT:
                begin
                    if (tick_reg && idle_reg == `TRD_SAMPLE_TICK)
                    begin
                        shift_reg <= word_full;
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        rx_state_reg <= word_done ? `TRD_RX_IDLE : `TRD_RX_WAIT;
                    end
                end
                `TRD_RX_WAIT:
                begin
                    if (rise)
                    begin
                        rx_state_reg <= `TRD_RX_BIT;
                    end
                    else if (word_abort)
                    begin
                        rx_state_reg <= `TRD_RX_IDLE;
                    end
                end
                default:
                begin
                    rx_state_reg <= `TRD_RX_IDLE;
                end
            endcase
            // a lost word breaks consecutiveness just as a gap does
            if (word_abort || seq_end || (fifo_in_valid && !fifo_in_ready)
                || (word_done && brk_pend_reg))
            begin
                brk_pend_reg <= 1'b1;
            end
            else if (brk_pend_reg && fifo_in_ready)
            begin
                brk_pend_reg <= 1'b0;
            end
            if (word_done && (!fifo_in_ready || brk_pend_reg))
            begin
                WORD_OVERRUN <= 1'b1;
            end
        end
    end

    wire fifo_out_valid;
    wire [`TRD_FIFO_W-1:0] fifo_out_data;
    wire fifo_out_ready;

    trd_fifo #(
        .W(`TRD_FIFO_W),
        .DEPTH(`TRD_FIFO_DEPTH),
        .AW(`TRD_FIFO_AW)
    ) u_fifo (
        .clk(CLK),
        .nrst(NRST),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    // comparator: load a word, check it next cycle, so it drains every other cycle
    reg cmp_state_reg;
    reg [`TRD_FIFO_W-1:0] cur_reg;
    reg prev_ok_reg;
    reg [3:0] prev_data_reg;
    wire [3:0] cur_data;
    wire addr_match;
    wire is_mark;

    assign fifo_out_ready = (cmp_state_reg == `TRD_CMP_IDLE);
    assign is_mark = cur_reg[`TRD_MARK_BIT];
    // a high digit is a one, low or open reads as zero
    assign cur_data = {cur_reg[1:0] == `TRD_DIG_HIGH, cur_reg[3:2] == `TRD_DIG_HIGH,
        cur_reg[5:4] == `TRD_DIG_HIGH, cur_reg[7:6] == `TRD_DIG_HIGH};
    assign addr_match = mode_addr_only
        ? (cur_reg[`TRD_WORD_W-1:0] == local_addr)
        : (cur_reg[`TRD_ADDR5_HI:`TRD_ADDR5_LO]
            == local_addr[`TRD_ADDR5_HI:`TRD_ADDR5_LO]);

    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            cmp_state_reg <= `TRD_CMP_IDLE;
            cur_reg <= {`TRD_FIFO_W{1'b0}};
            prev_ok_reg <= 1'b0;
            prev_data_reg <= 4'h0;
            DATA_OUT_BIT0 <= 1'b0;
            DATA_OUT_BIT1 <= 1'b0;
            DATA_OUT_BIT2 <= 1'b0;
            DATA_OUT_BIT3 <= 1'b0;
            VALID_FRAME_FLAG <= 1'b0;
        end
        else
        begin
            case (cmp_state_reg)
                `TRD_CMP_IDLE:
                begin
                    if (fifo_out_valid)
                    begin
                        cur_reg <= fifo_out_data;
                        cmp_state_reg <= `TRD_CMP_CHECK;
                    end
                end
                `TRD_CMP_CHECK:
                begin
                    cmp_state_reg <= `TRD_CMP_IDLE;
                    if (is_mark || !addr_match)
                    begin
                        prev_ok_reg <= 1'b0;
                        VALID_FRAME_FLAG <= 1'b0;
                    end
                    else
                    begin
                        prev_ok_reg <= 1'b1;
                        prev_data_reg <= cur_data;
                        if (prev_ok_reg && (mode_addr_only || cur_data == prev_data_reg))
                        begin
                            VALID_FRAME_FLAG <= 1'b1;
                            DATA_OUT_BIT0 <= cur_data[0];
                            DATA_OUT_BIT1 <= cur_data[1];
                            DATA_OUT_BIT2 <= cur_data[2];
                            DATA_OUT_BIT3 <= cur_data[3];
                        end
                        else if (prev_ok_reg)
                        begin
                            VALID_FRAME_FLAG <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    cmp_state_reg <= `TRD_CMP_IDLE;
                end
            endcase
        end
    end
endmodule

/* trd_decoder_asserts.sv */
// port-level checker for the trinary remote decoder, bound below
`timescale 1ns/1ps
module trd_decoder_chk (
    input logic CLK,
    input logic NRST,
    input logic SERIAL_IN,
    input logic ADDR_ONLY_MODE,
    input logic [17:0] LOCAL_ADDR_DIGITS,
    input logic DATA_OUT_BIT0,
    input logic DATA_OUT_BIT1,
    input logic DATA_OUT_BIT2,
    input logic DATA_OUT_BIT3,
    input logic VALID_FRAME_FLAG,
    input logic WORD_OVERRUN
);
    logic line_reg;
    logic [15:0] since_reg;
    logic [5:0] edges_reg;
    wire rise = SERIAL_IN && !line_reg;
    wire flag = VALID_FRAME_FLAG;
    wire [3:0] dout = {DATA_OUT_BIT3, DATA_OUT_BIT2, DATA_OUT_BIT1, DATA_OUT_BIT0};
    // a word resolves nine ticks after its last bit edge (tick phase unknown), plus
    // four cycles of input filter and three of fifo and compare pipeline
    wire in_win = since_reg >= 16'h03EE && since_reg <= 16'h046E;
    always_ff @(posedge CLK)
    begin
        line_reg <= SERIAL_IN & NRST;
        if (!NRST)
            since_reg <= 16'hFFFF;
        else if (rise)
            since_reg <= 16'h0000;
        else if (since_reg != 16'hFFFF)
            since_reg <= since_reg + 16'h0001;
        // a long quiet line ends the sequence, so bit edges count afresh
        if (!NRST)
            edges_reg <= 6'h00;
        else if (rise)
            edges_reg <= (since_reg >= 16'h3E80) ? 6'h01 : edges_reg + {5'h00, edges_reg != 6'h3F};
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    property p_rst;
        disable iff (1'b0) !NRST |=> !flag && dout == 4'h0 && !WORD_OVERRUN;
    endproperty
    a_rst: assert property (p_rst) else $error("output set in reset");
    property p_release;
        disable iff (1'b0) $rose(NRST) |-> ##1 !flag && dout == 4'h0;
    endproperty
    a_release: assert property (p_release) else $error("output set after release");
    property p_data_flag;
        $changed(dout) |-> flag;
    endproperty
    a_data_flag: assert property (p_data_flag) else $error("data moved without flag");
    property p_when;
        $rose(flag) || $changed(dout) |-> in_win;
    endproperty
    a_when: assert property (p_when) else $error("update outside word end");
    property p_pair;
        $rose(flag) |-> edges_reg >= 6'h24;
    endproperty
    a_pair: assert property (p_pair) else $error("flag before two words");
    property p_hold;
        flag && $past(flag) |-> $stable(dout);
    endproperty
    a_hold: assert property (p_hold) else $error("data changed under flag");
    property p_fall_hold;
        $fell(flag) |-> $stable(dout);
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("data moved on drop");
    property p_fall_when;
        $fell(flag) |-> since_reg >= 16'h03EE;
    endproperty
    a_fall_when: assert property (p_fall_when) else $error("early flag drop");
    c_rise: cover property ($rose(flag));
    c_fall: cover property ($fell(flag));
    c_reset: cover property (disable iff (1'b0) flag ##1 !NRST);
endmodule
bind trd_decoder trd_decoder_chk i_trd_decoder_chk (.CLK(CLK), .NRST(NRST),
    .SERIAL_IN(SERIAL_IN), .ADDR_ONLY_MODE(ADDR_ONLY_MODE),
    .LOCAL_ADDR_DIGITS(LOCAL_ADDR_DIGITS), .DATA_OUT_BIT0(DATA_OUT_BIT0),
    .DATA_OUT_BIT1(DATA_OUT_BIT1), .DATA_OUT_BIT2(DATA_OUT_BIT2),
    .DATA_OUT_BIT3(DATA_OUT_BIT3), .VALID_FRAME_FLAG(VALID_FRAME_FLAG),
    .WORD_OVERRUN(WORD_OVERRUN));

/* trd_encoder_model.sv */
// behavioural remote encoder driving the demodulated serial line
`timescale 1ns/1ps
module trd_encoder_model (
    input logic clk,
    input logic transmit_trigger,
    input logic [17:0] word,
    input logic [1:0] word_count,
    output logic serial_line,
    output logic busy
);
    // short cells keep the run brief: the decoder samples 1006..1130 cycles after a
    // cell's rising edge, so a one must stay high and the next edge must wait past that
    localparam int CELL = 1150;
    localparam int HIGH_ONE = 1136;
    localparam int HIGH_ZERO = 125;
    int rep;
    int b;
    int hi;
    initial
    begin
        serial_line = 1'b0;
        busy = 1'b0;
    end
    always @(posedge clk)
    begin
        if (transmit_trigger && !busy)
        begin
            busy <= 1'b1;
            for (rep = 0; rep < word_count; rep++)
            begin
                for (b = 17; b >= 0; b--)
                begin
                    hi = word[b] ? HIGH_ONE : HIGH_ZERO;
                    serial_line <= 1'b1;
                    repeat (hi) @(posedge clk);
                    serial_line <= 1'b0;
                    repeat (CELL - hi) @(posedge clk);
                end
            end
            busy <= 1'b0;
        end
    end
endmodule

/* trinary_remote_decoder_test.sv */
// table-driven bench: encoder model feeds the decoder, outputs are compared
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module trinary_remote_decoder_test;
    typedef struct packed {
        logic [17:0] word;
        logic [1:0] count;
        logic flag;
        logic [3:0] data;
    } trd_row_t;
    trd_row_t rows [0:1];
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic addr_only = 1'b0;
    logic [17:0] local_addr = 18'h00000;
    logic go = 1'b0;
    logic [17:0] tx_word = 18'h00000;
    logic [1:0] tx_count = 2'h2;
    wire line;
    wire busy;
    wire valid;
    wire overrun;
    wire [3:0] dout;
    int err_count = 0;
    int checks = 0;
    int i;
    always #4 clk = ~clk;
    trd_decoder i_trd_decoder (.CLK(clk), .NRST(nrst), .SERIAL_IN(line),
        .ADDR_ONLY_MODE(addr_only), .LOCAL_ADDR_DIGITS(local_addr),
        .DATA_OUT_BIT0(dout[0]), .DATA_OUT_BIT1(dout[1]), .DATA_OUT_BIT2(dout[2]),
        .DATA_OUT_BIT3(dout[3]), .VALID_FRAME_FLAG(valid), .WORD_OVERRUN(overrun));
    trd_encoder_model i_trd_encoder_model (.clk(clk), .transmit_trigger(go),
        .word(tx_word), .word_count(tx_count), .serial_line(line), .busy(busy));
    task automatic final_report();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic reset_to(input logic mode, input logic [17:0] addr);
        @(posedge clk);
        nrst <= 1'b0;
        addr_only <= mode;
        local_addr <= addr;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic send(input logic [17:0] w, input logic [1:0] n);
        int k;
        k = 0;
        @(posedge clk);
        tx_word <= w;
        tx_count <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1 && k < 50000)
        begin
            @(posedge clk);
            k++;
        end
        repeat (20) @(posedge clk);
    endtask
    initial
    begin
        rows[0] = '{18'h38ECC, 2'h2, 1'b1, 4'h5};
        // single word with new data right after a confirmed pair
        rows[1] = '{18'h38E33, 2'h1, 1'b0, 4'h5};
        // local digits 6..9 differ from the sent ones, so only five may be compared
        reset_to(1'b0, 18'h38E00);
        for (i = 0; i < 2; i++)
        begin
            send(rows[i].word, rows[i].count);
            `CHK(valid, rows[i].flag)
            `CHK(dout, rows[i].data)
        end
        reset_to(1'b1, 18'h2CBC8);
        `CHK({valid, dout, overrun}, 6'h00)
        send(18'h2CBC8, 2'h2);
        `CHK(valid, 1'b1)
        final_report();
    end
    initial
    begin
        repeat (110000) @(posedge clk);
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        err_count++;
        final_report();
    end
endmodule
